// File: src/sac_pkg.sv
// Overview of operation
// - External enable picks port A pin 0 reference
// - Otherwise select field: supply, 4V, 3V, 2V
// - Low reference tied to ground permanently
// - Channel gate low connects no analog source
// - Channel field maps pins, quarter supply, ground
// - Analog config bit isolates pin digital function
// - One bit decision per converter clock
// - Clock select divides fast RC clock
// - Sample width 1, 2, 4, 8 converter clocks
// - Resolution select gives 8, 10, 12 bits
// - Conversion lasts sample plus bits plus two
// - Offset adjust register trims result at run time
// - Enable, start; end flag low while busy
// - End flag rise with enables raises interrupt
package sac_pkg;

	// ==========================================================
	// Register map
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_CHAN = 4'h1;
	localparam logic [3:0] REG_REF = 4'h2;
	localparam logic [3:0] REG_TIMING = 4'h3;
	localparam logic [3:0] REG_PA_CFG = 4'h4;
	localparam logic [3:0] REG_PB_CFG = 4'h5;
	localparam logic [3:0] REG_OFFSET = 4'h6;
	localparam logic [3:0] REG_DATA_H = 4'h7;
	localparam logic [3:0] REG_DATA_L = 4'h8;

	// ==========================================================
	// Field positions
	localparam int unsigned CTRL_ENABLE = 0;
	localparam int unsigned CTRL_START = 1;
	localparam int unsigned CTRL_EOC = 2;
	localparam int unsigned CTRL_GATE = 3;
	localparam int unsigned CTRL_IRQ_EN = 4;
	localparam int unsigned REF_EXT = 2;
	localparam int unsigned TIM_CLK_LSB = 0;
	localparam int unsigned TIM_SW_LSB = 2;
	localparam int unsigned TIM_RES_LSB = 4;

	// ==========================================================
	// Encodings and counts
	localparam logic [1:0] CLK_DIV16 = 2'h0;
	localparam logic [1:0] CLK_DIV8 = 2'h1;
	localparam logic [1:0] CLK_DIV1 = 2'h2;
	localparam logic [1:0] CLK_DIV2 = 2'h3;
	localparam logic [3:0] DIV_LAST_16 = 4'hf;
	localparam logic [3:0] DIV_LAST_8 = 4'h7;
	localparam logic [3:0] DIV_LAST_1 = 4'h0;
	localparam logic [3:0] DIV_LAST_2 = 4'h1;
	localparam logic [1:0] SW_1 = 2'h0;
	localparam logic [1:0] SW_2 = 2'h1;
	localparam logic [1:0] SW_4 = 2'h2;
	localparam logic [3:0] SW_LAST_1 = 4'h0;
	localparam logic [3:0] SW_LAST_2 = 4'h1;
	localparam logic [3:0] SW_LAST_4 = 4'h3;
	localparam logic [3:0] SW_LAST_8 = 4'h7;
	localparam logic [1:0] RES_8 = 2'h0;
	localparam logic [1:0] RES_10 = 2'h1;
	localparam logic [3:0] LSB_8 = 4'h4;
	localparam logic [3:0] LSB_10 = 4'h2;
	localparam logic [3:0] LSB_12 = 4'h0;
	localparam logic [3:0] BIT_MSB = 4'hb;
	localparam logic [11:0] DAC_MSB_CODE = 12'h800;
	localparam logic [3:0] TAIL_LAST = 4'h1;
	localparam logic [1:0] IREF_VDD = 2'h3;
	localparam logic [1:0] IREF_4V = 2'h2;
	localparam logic [1:0] IREF_3V = 2'h1;
	localparam logic [4:0] HR_PA0 = 5'h01;
	localparam logic [4:0] HR_VDD = 5'h02;
	localparam logic [4:0] HR_4V = 5'h04;
	localparam logic [4:0] HR_3V = 5'h08;
	localparam logic [4:0] HR_2V = 5'h10;
	localparam int unsigned MUX_W = 14;
	localparam logic [3:0] CH_QUARTER = 4'hc;
	localparam logic [3:0] CH_VSS = 4'hd;
	localparam logic [13:0] MUX_ONE = 14'h0001;

	// Sequencer states, one-hot
	typedef enum logic [3:0] {
		st_idle = 4'h1,
		st_sample = 4'h2,
		st_convert = 4'h4,
		st_tail = 4'h8
	} sac_state_t;

endpackage

// File: src/sac_div_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Divider select out, converter clock tick back
interface sac_div_if;
	logic [1:0] sel;
	logic tick;
	modport src (input sel, output tick);
	modport snk (output sel, input tick);
endinterface
`default_nettype wire

// File: src/sac_conv_div.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Converter clock divider: one-cycle tick per converter period
module sac_conv_div (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Select in, tick out
	sac_div_if.src bus
);
	logic [3:0] cnt_ff;
	logic tick_ff;
	logic [3:0] nxt_cnt;
	logic nxt_tick;
	logic [3:0] last;

	// Terminal count per select; div-by-1 ticks every cycle
	always_comb begin
		last = sac_pkg::DIV_LAST_16;
		unique case (bus.sel)
			sac_pkg::CLK_DIV16: last = sac_pkg::DIV_LAST_16;
			sac_pkg::CLK_DIV8: last = sac_pkg::DIV_LAST_8;
			sac_pkg::CLK_DIV1: last = sac_pkg::DIV_LAST_1;
			sac_pkg::CLK_DIV2: last = sac_pkg::DIV_LAST_2;
		endcase
		nxt_tick = (cnt_ff >= last);
		nxt_cnt = nxt_tick ? 4'h0 : cnt_ff + 4'h1;
	end

	// Registers only
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cnt_ff <= 4'h0;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign bus.tick = tick_ff;

	// Divide by 8 spacing while the select holds
	property p_div8;
		@(posedge sys_clk) disable iff (reset)
		tick_ff && bus.sel == sac_pkg::CLK_DIV8 && $past(bus.sel) == sac_pkg::CLK_DIV8
		|=> (!tick_ff || bus.sel != sac_pkg::CLK_DIV8)[*7]
		##1 (tick_ff || bus.sel != sac_pkg::CLK_DIV8);
	endproperty
	a_div8: assert property (p_div8) else $error("divide by 8 spacing wrong");
endmodule
`default_nettype wire

// File: src/sac_adc_ctrl.sv
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Successive-approximation converter control
module sac_adc_ctrl (
	// Clock and reset; sys_clk is the fast RC clock
	input wire logic sys_clk,
	input wire logic reset,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	// Core side
	input wire logic global_irq_enable,
	output logic conv_irq,
	// Analog front end
	input wire logic cmp_above,
	output logic bias_enable,
	output logic [4:0] high_ref_sel,
	output logic low_ref_gnd,
	output logic [13:0] mux_sel,
	output logic sample_hold,
	output logic [11:0] dac_code,
	// Pin analog configuration
	output logic [4:0] porta_analog_cfg,
	output logic [7:1] portb_analog_cfg
);
	// ==========================================================
	// Declarations
	logic conv_enable_ff, global_channel_gate_ff, conv_irq_enable_ff;
	logic [3:0] channel_select_ff;
	logic [1:0] int_ref_select_ff;
	logic ext_ref_enable_ff;
	logic [1:0] conv_clock_select_ff, sample_width_select_ff, resolution_select_ff;
	logic [4:0] pa_cfg_ff;
	logic [7:1] pb_cfg_ff;
	logic [7:0] offset_adjust_ff;
	logic [7:0] rdata_ff;
	logic nxt_conv_enable, nxt_gate, nxt_irq_en, nxt_ext_ref;
	logic [3:0] nxt_chan;
	logic [1:0] nxt_int_ref, nxt_clk_sel, nxt_sw_sel, nxt_res_sel;
	logic [4:0] nxt_pa_cfg;
	logic [7:1] nxt_pb_cfg;
	logic [7:0] nxt_offset, nxt_rdata;
	sac_pkg::sac_state_t state_ff, nxt_state;
	logic [3:0] cnt_ff, nxt_cnt, bit_ff, nxt_bit;
	logic [11:0] dac_ff, nxt_dac, result_ff, nxt_result;
	logic sample_ff, nxt_sample, start_ff, nxt_start, eoc_ff, nxt_eoc;
	logic irq_ff, nxt_irq;
	logic cmp_meta_ff, cmp_sync_ff;
	logic [4:0] hr_sel_ff, nxt_hr_sel;
	logic [13:0] mux_ff, nxt_mux;
	logic low_ref_ff;
	logic start_req, tick, irq_gate;
	logic [4:0] wdata_pa;

	sac_div_if div_bus ();

	sac_conv_div u_div (
		.sys_clk(sys_clk),
		.reset(reset),
		.bus(div_bus.src)
	);

	assign div_bus.sel = conv_clock_select_ff;
	assign tick = div_bus.tick;
	assign irq_gate = conv_irq_enable_ff & global_irq_enable;
	assign wdata_pa = wdata[4:0];
	assign start_req = wr_en && addr == sac_pkg::REG_CTRL && wdata[sac_pkg::CTRL_START]
		&& wdata[sac_pkg::CTRL_ENABLE];

	// ==========================================================
	// Decode functions
	function automatic logic [3:0] sw_last(input logic [1:0] sel);
		logic [3:0] r;
		r = sac_pkg::SW_LAST_8;
		unique case (sel)
			sac_pkg::SW_1: r = sac_pkg::SW_LAST_1;
			sac_pkg::SW_2: r = sac_pkg::SW_LAST_2;
			sac_pkg::SW_4: r = sac_pkg::SW_LAST_4;
			default: r = sac_pkg::SW_LAST_8;
		endcase
		return r;
	endfunction

	function automatic logic [3:0] lsb_of(input logic [1:0] res);
		logic [3:0] r;
		r = sac_pkg::LSB_12;
		if (res == sac_pkg::RES_8) begin
			r = sac_pkg::LSB_8;
		end else if (res == sac_pkg::RES_10) begin
			r = sac_pkg::LSB_10;
		end
		return r;
	endfunction

	// Signed trim on the 12-bit scale, saturating at both ends
	function automatic logic [11:0] trim(input logic [11:0] raw, input logic [7:0] off);
		logic [13:0] sum;
		logic [11:0] r;
		sum = {2'h0, raw} + {{6{off[7]}}, off};
		r = sum[11:0];
		if (sum[13]) begin
			r = 12'h000;
		end else if (sum[12]) begin
			r = 12'hfff;
		end
		return r;
	endfunction

	// ==========================================================
	// Register file: writes and one-cycle-late read data
	always_comb begin
		nxt_conv_enable = conv_enable_ff;
		nxt_gate = global_channel_gate_ff;
		nxt_irq_en = conv_irq_enable_ff;
		nxt_chan = channel_select_ff;
		nxt_int_ref = int_ref_select_ff;
		nxt_ext_ref = ext_ref_enable_ff;
		nxt_clk_sel = conv_clock_select_ff;
		nxt_sw_sel = sample_width_select_ff;
		nxt_res_sel = resolution_select_ff;
		nxt_pa_cfg = pa_cfg_ff;
		nxt_pb_cfg = pb_cfg_ff;
		nxt_offset = offset_adjust_ff;
		nxt_rdata = 8'h00;
		if (wr_en) begin
			unique case (addr)
				sac_pkg::REG_CTRL: begin
					nxt_conv_enable = wdata[sac_pkg::CTRL_ENABLE];
					nxt_gate = wdata[sac_pkg::CTRL_GATE];
					nxt_irq_en = wdata[sac_pkg::CTRL_IRQ_EN];
				end
				sac_pkg::REG_CHAN: nxt_chan = wdata[3:0];
				sac_pkg::REG_REF: begin
					nxt_int_ref = wdata[1:0];
					nxt_ext_ref = wdata[sac_pkg::REF_EXT];
				end
				sac_pkg::REG_TIMING: begin
					nxt_clk_sel = wdata[sac_pkg::TIM_CLK_LSB +: 2];
					nxt_sw_sel = wdata[sac_pkg::TIM_SW_LSB +: 2];
					nxt_res_sel = wdata[sac_pkg::TIM_RES_LSB +: 2];
				end
				sac_pkg::REG_PA_CFG: nxt_pa_cfg = wdata[4:0];
				sac_pkg::REG_PB_CFG: nxt_pb_cfg = wdata[7:1];
				sac_pkg::REG_OFFSET: nxt_offset = wdata;
				default: ;
			endcase
		end
		// Unmapped reads and cycles without a read strobe answer zero
		if (rd_en) begin
			unique case (addr)
				sac_pkg::REG_CTRL: nxt_rdata = {3'h0, conv_irq_enable_ff,
					global_channel_gate_ff, eoc_ff, start_ff, conv_enable_ff};
				sac_pkg::REG_CHAN: nxt_rdata = {4'h0, channel_select_ff};
				sac_pkg::REG_REF: nxt_rdata = {5'h00, ext_ref_enable_ff, int_ref_select_ff};
				sac_pkg::REG_TIMING: nxt_rdata = {2'h0, resolution_select_ff,
					sample_width_select_ff, conv_clock_select_ff};
				sac_pkg::REG_PA_CFG: nxt_rdata = {3'h0, pa_cfg_ff};
				sac_pkg::REG_PB_CFG: nxt_rdata = {pb_cfg_ff, 1'b0};
				sac_pkg::REG_OFFSET: nxt_rdata = offset_adjust_ff;
				sac_pkg::REG_DATA_H: nxt_rdata = result_ff[11:4];
				sac_pkg::REG_DATA_L: nxt_rdata = {4'h0, result_ff[3:0]};
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	// Register file flops
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			conv_enable_ff <= 1'b0;
			global_channel_gate_ff <= 1'b0;
			conv_irq_enable_ff <= 1'b0;
			channel_select_ff <= 4'h0;
			int_ref_select_ff <= 2'h0;
			ext_ref_enable_ff <= 1'b0;
			conv_clock_select_ff <= 2'h0;
			sample_width_select_ff <= 2'h0;
			resolution_select_ff <= 2'h0;
			pa_cfg_ff <= 5'h00;
			pb_cfg_ff <= 7'h00;
			offset_adjust_ff <= 8'h00;
			rdata_ff <= 8'h00;
		end else begin
			conv_enable_ff <= nxt_conv_enable;
			global_channel_gate_ff <= nxt_gate;
			conv_irq_enable_ff <= nxt_irq_en;
			channel_select_ff <= nxt_chan;
			int_ref_select_ff <= nxt_int_ref;
			ext_ref_enable_ff <= nxt_ext_ref;
			conv_clock_select_ff <= nxt_clk_sel;
			sample_width_select_ff <= nxt_sw_sel;
			resolution_select_ff <= nxt_res_sel;
			pa_cfg_ff <= nxt_pa_cfg;
			pb_cfg_ff <= nxt_pb_cfg;
			offset_adjust_ff <= nxt_offset;
			rdata_ff <= nxt_rdata;
		end
	end

	// ==========================================================
	// Comparator synchroniser; only the second stage is read
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cmp_meta_ff <= 1'b0;
			cmp_sync_ff <= 1'b0;
		end else begin
			cmp_meta_ff <= cmp_above;
			cmp_sync_ff <= cmp_meta_ff;
		end
	end

	// ==========================================================
	// Sequencer: sample, one decision per tick, two-clock tail.
	// The sync delay is two system cycles; at div-by-1 and div-by-2 the
	// decision reads a comparator sample taken before the trial code is driven, a known limit.
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_bit = bit_ff;
		nxt_dac = dac_ff;
		nxt_sample = sample_ff;
		nxt_start = start_ff;
		nxt_eoc = eoc_ff;
		nxt_result = result_ff;
		nxt_irq = 1'b0;
		if (!conv_enable_ff && state_ff != sac_pkg::st_idle) begin
			// Disable aborts; start drops, flag stays low
			nxt_state = sac_pkg::st_idle;
			nxt_sample = 1'b0;
			nxt_start = 1'b0;
		end else begin
			unique case (state_ff)
				sac_pkg::st_idle: begin
					if (start_req) begin
						nxt_state = sac_pkg::st_sample;
						nxt_cnt = 4'h0;
						nxt_sample = 1'b1;
						nxt_start = 1'b1;
						nxt_eoc = 1'b0;
						nxt_dac = 12'h000;
					end
				end
				sac_pkg::st_sample: begin
					if (tick) begin
						if (cnt_ff == sw_last(sample_width_select_ff)) begin
							nxt_state = sac_pkg::st_convert;
							nxt_sample = 1'b0;
							nxt_bit = sac_pkg::BIT_MSB;
							nxt_dac = sac_pkg::DAC_MSB_CODE;
						end else begin
							nxt_cnt = cnt_ff + 4'h1;
						end
					end
				end
				sac_pkg::st_convert: begin
					if (tick) begin
						// Keep the trial bit only if input is above it
						if (!cmp_sync_ff) begin
							nxt_dac[bit_ff] = 1'b0;
						end
						if (bit_ff == lsb_of(resolution_select_ff)) begin
							nxt_state = sac_pkg::st_tail;
							nxt_cnt = 4'h0;
						end else begin
							nxt_bit = bit_ff - 4'h1;
							nxt_dac[bit_ff - 4'h1] = 1'b1;
						end
					end
				end
				sac_pkg::st_tail: begin
					if (tick) begin
						if (cnt_ff == sac_pkg::TAIL_LAST) begin
							nxt_state = sac_pkg::st_idle;
							nxt_start = 1'b0;
							nxt_eoc = 1'b1;
							nxt_result = trim(dac_ff, offset_adjust_ff);
							nxt_irq = irq_gate;
						end else begin
							nxt_cnt = cnt_ff + 4'h1;
						end
					end
				end
				default: begin
					nxt_state = sac_pkg::st_idle;
					nxt_sample = 1'b0;
					nxt_start = 1'b0;
				end
			endcase
		end
	end

	// Sequencer flops
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_ff <= sac_pkg::st_idle;
			cnt_ff <= 4'h0;
			bit_ff <= 4'h0;
			dac_ff <= 12'h000;
			sample_ff <= 1'b0;
			start_ff <= 1'b0;
			eoc_ff <= 1'b0;
			result_ff <= 12'h000;
			irq_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			bit_ff <= nxt_bit;
			dac_ff <= nxt_dac;
			sample_ff <= nxt_sample;
			start_ff <= nxt_start;
			eoc_ff <= nxt_eoc;
			result_ff <= nxt_result;
			irq_ff <= nxt_irq;
		end
	end

	// ==========================================================
	// Analog routing decode, registered so switches never glitch
	always_comb begin
		nxt_hr_sel = sac_pkg::HR_2V;
		if (ext_ref_enable_ff) begin
			nxt_hr_sel = sac_pkg::HR_PA0;
		end else begin
			unique case (int_ref_select_ff)
				sac_pkg::IREF_VDD: nxt_hr_sel = sac_pkg::HR_VDD;
				sac_pkg::IREF_4V: nxt_hr_sel = sac_pkg::HR_4V;
				sac_pkg::IREF_3V: nxt_hr_sel = sac_pkg::HR_3V;
				default: nxt_hr_sel = sac_pkg::HR_2V;
			endcase
		end
		// Codes above ground leave the input open
		nxt_mux = 14'h0000;
		if (global_channel_gate_ff && channel_select_ff <= sac_pkg::CH_VSS) begin
			nxt_mux = sac_pkg::MUX_ONE << channel_select_ff;
		end
	end

	// Routing flops; low reference has no control at all
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			hr_sel_ff <= sac_pkg::HR_2V;
			mux_ff <= 14'h0000;
			low_ref_ff <= 1'b1;
		end else begin
			hr_sel_ff <= nxt_hr_sel;
			mux_ff <= nxt_mux;
			low_ref_ff <= 1'b1;
		end
	end

	// ==========================================================
	// Outputs, all straight from flops
	assign rdata = rdata_ff;
	assign conv_irq = irq_ff;
	assign bias_enable = conv_enable_ff;
	assign high_ref_sel = hr_sel_ff;
	assign low_ref_gnd = low_ref_ff;
	assign mux_sel = mux_ff;
	assign sample_hold = sample_ff;
	assign dac_code = dac_ff;
	assign porta_analog_cfg = pa_cfg_ff;
	assign portb_analog_cfg = pb_cfg_ff;

	// ==========================================================
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	property p_ext_ref;
		ext_ref_enable_ff |=> hr_sel_ff == sac_pkg::HR_PA0;
	endproperty
	a_ext_ref: assert property (p_ext_ref) else $error("external ref not chosen");

	property p_int_ref;
		!ext_ref_enable_ff && int_ref_select_ff == sac_pkg::IREF_4V |=> hr_sel_ff == sac_pkg::HR_4V;
	endproperty
	a_int_ref: assert property (p_int_ref) else $error("4V ref not chosen");

	property p_low_ref;
		low_ref_gnd;
	endproperty
	a_low_ref: assert property (p_low_ref) else $error("low ref left ground");

	property p_gate;
		!global_channel_gate_ff |=> mux_sel == 14'h0000;
	endproperty
	a_gate: assert property (p_gate) else $error("source routed with gate off");

	property p_quarter;
		global_channel_gate_ff && channel_select_ff == sac_pkg::CH_QUARTER
		|=> mux_sel == (sac_pkg::MUX_ONE << sac_pkg::CH_QUARTER);
	endproperty
	a_quarter: assert property (p_quarter) else $error("quarter supply not routed");

	property p_pa_cfg;
		wr_en && addr == sac_pkg::REG_PA_CFG |=> porta_analog_cfg == $past(wdata_pa);
	endproperty
	a_pa_cfg: assert property (p_pa_cfg) else $error("port A analog cfg not taken");

	property p_bit_step;
		state_ff == sac_pkg::st_convert && tick && bit_ff != lsb_of(resolution_select_ff)
		|=> bit_ff == $past(bit_ff) - 4'h1;
	endproperty
	a_bit_step: assert property (p_bit_step) else $error("bit decision skipped");

	property p_sample8;
		$rose(sample_ff) && conv_clock_select_ff == sac_pkg::CLK_DIV1
		&& sample_width_select_ff == 2'h3 |-> sample_ff[*8] ##1 !sample_ff;
	endproperty
	a_sample8: assert property (p_sample8) else $error("sample width not 8");

	property p_res8;
		$rose(state_ff == sac_pkg::st_convert) && resolution_select_ff == sac_pkg::RES_8
		&& conv_clock_select_ff == sac_pkg::CLK_DIV1
		|-> (state_ff == sac_pkg::st_convert)[*8] ##1 (state_ff == sac_pkg::st_tail);
	endproperty
	a_res8: assert property (p_res8) else $error("8-bit convert length wrong");

	property p_total;
		$rose(state_ff != sac_pkg::st_idle) && conv_clock_select_ff == sac_pkg::CLK_DIV1
		&& sample_width_select_ff == sac_pkg::SW_1 && resolution_select_ff[1]
		|-> ##14 !eoc_ff ##1 eoc_ff;
	endproperty
	a_total: assert property (p_total) else $error("conversion time not 15");

	property p_start_eoc;
		state_ff == sac_pkg::st_idle && start_req |=> !eoc_ff && start_ff;
	endproperty
	a_start_eoc: assert property (p_start_eoc) else $error("start not taken");

	property p_irq;
		$rose(eoc_ff) |-> conv_irq == $past(irq_gate);
	endproperty
	a_irq: assert property (p_irq) else $error("irq not tied to end flag");

	property p_start_clr;
		$rose(eoc_ff) |-> !start_ff && state_ff == sac_pkg::st_idle;
	endproperty
	a_start_clr: assert property (p_start_clr) else $error("start not cleared at end");

	c_full: cover property ($rose(eoc_ff) && resolution_select_ff[1]);
	c_short: cover property ($rose(eoc_ff) && resolution_select_ff == sac_pkg::RES_8);
	c_irq: cover property (conv_irq);
	c_abort: cover property (state_ff != sac_pkg::st_idle && !conv_enable_ff);
endmodule
`default_nettype wire

// File: sim/sac_adc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Register-level bench for the converter control
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin err_count++; \
	$display("[FAIL] %s exp %h got %h", n, e, a); end end
module sac_adc_ctrl_tb;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic global_irq_enable = 1'b1;
	logic cmp_above = 1'b1;
	logic [7:0] rdata, rv;
	logic conv_irq, bias_enable, low_ref_gnd, sample_hold;
	logic [4:0] high_ref_sel, porta_analog_cfg;
	logic [13:0] mux_sel;
	logic [11:0] dac_code;
	logic [7:1] portb_analog_cfg;
	int err_count = 0;
	int checks = 0;
	int irq_cnt = 0;
	int n0;
	sac_adc_ctrl sac_adc_ctrl_i (.sys_clk(sys_clk), .reset(reset), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .global_irq_enable(global_irq_enable),
		.conv_irq(conv_irq), .cmp_above(cmp_above), .bias_enable(bias_enable),
		.high_ref_sel(high_ref_sel), .low_ref_gnd(low_ref_gnd), .mux_sel(mux_sel),
		.sample_hold(sample_hold), .dac_code(dac_code), .porta_analog_cfg(porta_analog_cfg),
		.portb_analog_cfg(portb_analog_cfg));
	always #20 sys_clk = ~sys_clk;
	// Pulse counter on the falling edge, clear of the launch edge
	always @(negedge sys_clk) begin
		if (conv_irq === 1'b1) begin
			irq_cnt++;
		end
	end
	task automatic end_of_test;
		if (err_count == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask
	// Read data only stand in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic settle;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	// Run one conversion; bounds allow for the free-running divider phase
	task automatic conv(input logic [1:0] cs, input logic [1:0] sw, input logic [1:0] rs,
		input logic [11:0] er);
		int d, s, n, cyc, sh;
		logic [11:0] raw;
		d = (cs == sac_pkg::CLK_DIV16) ? 16 : (cs == sac_pkg::CLK_DIV8) ? 8 : (cs == 2'h2) ? 1 : 2;
		s = 1 << sw;
		n = (rs == 2'h0) ? 8 : (rs == 2'h1) ? 10 : 12;
		cyc = 0;
		sh = 0;
		// Untrimmed code: kept bits down to the last converted one
		raw = (cmp_above === 1'b1) ? 12'hfff << (12 - n) : 12'h000;
		wr(sac_pkg::REG_TIMING, {2'h0, rs, sw, cs});
		rd(sac_pkg::REG_TIMING, rv);
		`CHK("timing rb", {2'h0, rs, sw, cs}, rv)
		wr(sac_pkg::REG_CTRL, 8'h1b);
		// First look in the cycle the start lands, so a one-clock sample counts
		#1;
		while (conv_irq !== 1'b1 && cyc < 600) begin
			if (sample_hold === 1'b1) begin
				sh++;
			end
			@(posedge sys_clk);
			#1 cyc++;
		end
		`CHK("dac code", raw, dac_code)
		`CHK("conv time", 1'b1, cyc > (s + n + 1) * d && cyc <= (s + n + 3) * d + 2)
		`CHK("sample span", 1'b1, sh > (s - 1) * d && sh <= s * d)
		rd(sac_pkg::REG_CTRL, rv);
		`CHK("ctrl done", 8'h1d, rv)
		rd(sac_pkg::REG_DATA_H, rv);
		`CHK("result hi", er[11:4], rv)
		rd(sac_pkg::REG_DATA_L, rv);
		`CHK("result lo", {4'h0, er[3:0]}, rv)
	endtask
	// Watchdog: the bias wait included, the run needs about 7800 cycles
	initial begin
		#800000;
		err_count++;
		end_of_test();
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		#1;
		`CHK("ref reset", 5'h10, high_ref_sel)
		`CHK("mux reset", 14'h0, mux_sel)
		// Every reference code with the external enable off and on
		for (int i = 0; i < 8; i++) begin
			wr(sac_pkg::REG_REF, 8'(i));
			settle();
			`CHK("high ref", i[2] ? 5'h01 : 5'(5'h10 >> i[1:0]), high_ref_sel)
			`CHK("low ref", 1'b1, low_ref_gnd)
			rd(sac_pkg::REG_REF, rv);
			`CHK("ref rb", 8'(i), rv)
		end
		// Every channel code with the gate open, then the gate shut
		wr(sac_pkg::REG_CTRL, 8'h08);
		for (int i = 0; i < 16; i++) begin
			wr(sac_pkg::REG_CHAN, 8'(i));
			settle();
			`CHK("mux open", (i < 14) ? (sac_pkg::MUX_ONE << i) : 14'h0, mux_sel)
			rd(sac_pkg::REG_CHAN, rv);
			`CHK("chan rb", 8'(i), rv)
		end
		wr(sac_pkg::REG_CHAN, 8'h03);
		wr(sac_pkg::REG_CTRL, 8'h00);
		settle();
		`CHK("mux gated", 14'h0, mux_sel)
		// Bench plays firmware: pins marked analog stay undriven, no pulls
		wr(sac_pkg::REG_PA_CFG, 8'h15);
		wr(sac_pkg::REG_PB_CFG, 8'hab);
		settle();
		`CHK("porta cfg", 5'h15, porta_analog_cfg)
		`CHK("portb cfg", 7'h55, portb_analog_cfg)
		rd(sac_pkg::REG_PA_CFG, rv);
		`CHK("porta rb", 8'h15, rv)
		rd(sac_pkg::REG_PB_CFG, rv);
		`CHK("portb rb", 8'haa, rv)
		rd(4'hf, rv);
		`CHK("unmapped", 8'h00, rv)
		// Enable first, then hold off starts while the bias settles
		wr(sac_pkg::REG_CTRL, 8'h19);
		repeat (6400) @(posedge sys_clk);
		// All clock, width and resolution codes
		conv(2'h2, 2'h0, 2'h2, 12'hfff);
		conv(2'h2, 2'h1, 2'h0, 12'hff0);
		conv(2'h3, 2'h2, 2'h1, 12'hffc);
		conv(2'h1, 2'h3, 2'h3, 12'hfff);
		conv(2'h0, 2'h3, 2'h2, 12'hfff);
		// Offset trim, saturating at both ends
		@(posedge sys_clk);
		cmp_above <= 1'b0;
		wr(sac_pkg::REG_OFFSET, 8'h05);
		conv(2'h2, 2'h0, 2'h2, 12'h005);
		wr(sac_pkg::REG_OFFSET, 8'hfb);
		conv(2'h2, 2'h0, 2'h2, 12'h000);
		@(posedge sys_clk);
		cmp_above <= 1'b1;
		wr(sac_pkg::REG_OFFSET, 8'h7f);
		conv(2'h2, 2'h0, 2'h2, 12'hfff);
		wr(sac_pkg::REG_OFFSET, 8'hff);
		rd(sac_pkg::REG_OFFSET, rv);
		`CHK("offset rb", 8'hff, rv)
		// Eight-clock sample at full speed, also reaches the sample check
		conv(2'h2, 2'h3, 2'h2, 12'hffe);
		// Each enable alone must hold the interrupt back
		for (int m = 0; m < 2; m++) begin
			@(posedge sys_clk);
			global_irq_enable <= m[0];
			n0 = irq_cnt;
			wr(sac_pkg::REG_CTRL, m[0] ? 8'h0b : 8'h1b);
			repeat (30) @(posedge sys_clk);
			rd(sac_pkg::REG_CTRL, rv);
			`CHK("ctrl masked", m[0] ? 8'h0d : 8'h1d, rv)
			`CHK("irq masked", n0, irq_cnt)
		end
		// Abort in mid-conversion at the slowest clock
		wr(sac_pkg::REG_TIMING, 8'h0c);
		wr(sac_pkg::REG_CTRL, 8'h1b);
		rd(sac_pkg::REG_CTRL, rv);
		`CHK("ctrl busy", 8'h1b, rv)
		`CHK("bias on", 1'b1, bias_enable)
		n0 = irq_cnt;
		wr(sac_pkg::REG_CTRL, 8'h18);
		repeat (400) @(posedge sys_clk);
		rd(sac_pkg::REG_CTRL, rv);
		`CHK("ctrl abort", 8'h18, rv)
		`CHK("irq abort", n0, irq_cnt)
		`CHK("bias off", 1'b0, bias_enable)
		end_of_test();
	end
endmodule
`default_nettype wire
